// >>> rtl/ovs_defines.svh
`ifndef OVS_DEFINES_SVH
`define OVS_DEFINES_SVH

// Register byte offsets
`define OFF_OVS_CTL 12'h080
`define OFF_RESULT 12'h04C
`define OFF_CONV_CTL 12'h008

// Oversampling control fields
`define OVS_ON_BIT 0
`define OVS_RATIO_LSB 2
`define OVS_RATIO_MSB 4
`define OVS_SHIFT_LSB 5
`define OVS_SHIFT_MSB 8
`define OVS_TPS_BIT 9
`define OVS_CTL_MASK 32'h0000_03FD
`define OVS_CTL_RESET 32'h0000_0000
`define OVS_SHIFT_MAX 4'h8

// Converter control: converter_on in bit 0
`define CONV_ON_BIT 0

`endif

// >>> rtl/ovs_pkg.sv
package ovs_pkg;
	// Oversampling settings as held in the control register
	typedef struct packed {
		logic tps;
		logic [3:0] shift;
		logic [2:0] ratio;
		logic on;
	} ovs_cfg_t;

	// One conversion sample from the converter core
	typedef struct packed {
		logic valid;
		logic [11:0] data;
	} sample_t;
endpackage : ovs_pkg

// >>> rtl/ovs_accum.sv
`timescale 1ns/1ps
`default_nettype none
// Sums samples of one group and delivers the shifted total
module ovs_accum
	import ovs_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Settings and control
	input wire ovs_pkg::ovs_cfg_t cfg,
	input wire logic clear,
	// Sample in
	input wire ovs_pkg::sample_t smp,
	// Result out
	output logic done,
	output logic [15:0] result
);
	logic [19:0] sum_q, sum_d;
	logic [8:0] cnt_q, cnt_d;
	logic [8:0] ratioCnt;
	logic lastSample;
	logic [19:0] shifted;

	// Group size is two raised to ratio plus one
	assign ratioCnt = 9'h002 << cfg.ratio;
	assign lastSample = smp.valid && (cnt_q + 9'h001 == ratioCnt);
	assign shifted = (sum_q + {8'h00, smp.data}) >> cfg.shift;
	assign sum_d = clear ? 20'h00000 : lastSample ? 20'h00000 :
		smp.valid ? sum_q + {8'h00, smp.data} : sum_q;
	assign cnt_d = clear ? 9'h000 : lastSample ? 9'h000 :
		smp.valid ? cnt_q + 9'h001 : cnt_q;

	// Running sum and sample count
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sum_q <= 20'h00000;
			cnt_q <= 9'h000;
		end
		else
		begin
			sum_q <= sum_d;
			cnt_q <= cnt_d;
		end
	end

	// Result only after the final sample; clipped to 16 bits
	assign done = lastSample && !clear;
	assign result = (shifted[19:16] != 4'h0) ? 16'hFFFF : shifted[15:0];
endmodule : ovs_accum
`default_nettype wire

// >>> rtl/adc_oversampling_control.sv
// Operation
// [R01] Trigger-per-sample off: whole group after one trigger
// [R02] Trigger-per-sample on: one trigger per sample
// [R03] Shift field bits 8:5, 0 to 8
// [R04] Ratio field bits 4:2, 2x to 256x
// [R05] Bit 0 turns oversampling on
// [R06] Software changes settings only with converter off
// [R07] Result sits in low 16 result bits
// [R08] Sum group, shift, update after last sample
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "ovs_defines.svh"
module adc_oversampling_control
	import ovs_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Trigger in, conversion request out
	input wire logic trigger,
	output logic convStart,
	// Converter core sample
	input wire logic sampleValid,
	input wire logic [11:0] sampleData,
	// Status
	output logic converterOn,
	output logic resultValid
);
	import ovs_pkg::*;

	typedef enum logic [1:0] {IDLE, CONVERT, WAITTRIG} state_t;
	state_t state_q, state_d;

	logic [31:0] ovsCtl_q;
	logic convOn_q;
	logic [15:0] result_q;
	logic resValid_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic convStart_q;
	logic [8:0] remain_q, remain_d;
	ovs_cfg_t cfg;
	sample_t smp;
	logic accDone;
	logic [15:0] accResult;
	logic groupDone;

	// Field view of the control register
	assign cfg.on = ovsCtl_q[`OVS_ON_BIT]; // R05
	assign cfg.ratio = ovsCtl_q[`OVS_RATIO_MSB:`OVS_RATIO_LSB]; // R04
	assign cfg.shift = ovsCtl_q[`OVS_SHIFT_MSB:`OVS_SHIFT_LSB]; // R03
	assign cfg.tps = ovsCtl_q[`OVS_TPS_BIT];
	assign smp.valid = sampleValid && state_q != IDLE;
	assign smp.data = sampleData;

	// APB decode: one wait state so every answer comes from a flop
	logic access;
	logic selCtl, selRes, selConv, selAny;
	logic wrCtl, wrConv;
	logic shiftBad;
	assign access = psel && penable && !pready_q;
	assign selCtl = paddr == `OFF_OVS_CTL;
	assign selRes = paddr == `OFF_RESULT;
	assign selConv = paddr == `OFF_CONV_CTL;
	assign selAny = selCtl || selRes || selConv;
	// Reserved shift codes above eight are refused with an error
	assign shiftBad = pwdata[`OVS_SHIFT_MSB:`OVS_SHIFT_LSB] > `OVS_SHIFT_MAX;
	// Settings writes while the converter runs are dropped
	assign wrCtl = access && pwrite && selCtl && !convOn_q && !shiftBad; // R06
	assign wrConv = access && pwrite && selConv;

	// Bus answer registers
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			pready_q <= access;
			pslverr_q <= access && (!selAny ||
				(pwrite && selRes) ||
				(pwrite && selCtl && (convOn_q || shiftBad)));
			prdata_q <= !access || pwrite ? 32'h0000_0000 :
				selCtl ? ovsCtl_q :
				selRes ? {16'h0000, result_q} : // R07
				selConv ? {31'h0000_0000, convOn_q} : 32'h0000_0000;
		end
	end

	// Control registers
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ovsCtl_q <= `OVS_CTL_RESET;
			convOn_q <= 1'b0;
		end
		else
		begin
			if (wrCtl)
				ovsCtl_q <= pwdata & `OVS_CTL_MASK;
			if (wrConv)
				convOn_q <= pwdata[`CONV_ON_BIT];
		end
	end

	// Sample sequencing: how many samples still to take in this group
	logic [8:0] groupSize;
	logic trigEv;
	assign groupSize = cfg.on ? (9'h002 << cfg.ratio) : 9'h001;
	assign trigEv = trigger && convOn_q;
	assign groupDone = smp.valid && remain_q == 9'h001;

	always_comb
	begin
		state_d = state_q;
		remain_d = remain_q;
		unique case (state_q)
			IDLE:
				if (trigEv)
				begin
					state_d = CONVERT;
					remain_d = groupSize;
				end
			CONVERT:
				if (smp.valid)
				begin
					remain_d = remain_q - 9'h001;
					if (groupDone)
						state_d = IDLE;
					else if (cfg.on && cfg.tps)
						state_d = WAITTRIG; // R02
					else
						state_d = CONVERT; // R01
				end
			WAITTRIG:
				if (trigEv)
					state_d = CONVERT; // R02
		endcase
		if (!convOn_q)
			state_d = IDLE;
	end

	// Request a conversion at group start, on a trigger in WAITTRIG, and after each non-final sample when not in trigger-per-sample mode
	logic startNext;
	assign startNext = (state_q == IDLE && trigEv) ||
		(state_q == WAITTRIG && trigEv) ||
		(state_q == CONVERT && smp.valid && !groupDone &&
		!(cfg.on && cfg.tps)); // R01

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q <= IDLE;
			remain_q <= 9'h000;
			convStart_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			remain_q <= remain_d;
			convStart_q <= startNext && convOn_q;
		end
	end

	ovs_accum u_accum (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.cfg(cfg),
		.clear(!convOn_q || state_q == IDLE),
		.smp(smp),
		.done(accDone),
		.result(accResult)
	);

	// Result register: direct sample or shifted sum at group end
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			result_q <= 16'h0000;
			resValid_q <= 1'b0;
		end
		else
		begin
			resValid_q <= 1'b0;
			if (cfg.on && accDone)
			begin
				result_q <= accResult; // R08
				resValid_q <= 1'b1;
			end
			else if (!cfg.on && groupDone)
			begin
				result_q <= {4'h0, sampleData}; // R07
				resValid_q <= 1'b1;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign convStart = convStart_q;
	assign converterOn = convOn_q;
	assign resultValid = resValid_q;

	// Checks
	sequence s_groupEnd;
		cfg.on && accDone;
	endsequence

	chk_result_update: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_groupEnd |=> resValid_q && result_q == $past(accResult)) // R08
		else $error("result not updated at group end");

	chk_ctl_locked: assert property (@(posedge sys_clk) disable iff (!nrst)
		convOn_q |=> $stable(ovsCtl_q)) // R06
		else $error("settings changed while converter on");

	chk_tps_wait: assert property (@(posedge sys_clk) disable iff (!nrst)
		(state_q == WAITTRIG && !trigEv) |=> !convStart_q) // R02
		else $error("conversion started without trigger");

	chk_back_back: assert property (@(posedge sys_clk) disable iff (!nrst)
		(state_q == CONVERT && smp.valid && !groupDone && !cfg.tps
		&& convOn_q) |=> convStart_q) // R01
		else $error("next conversion not started");

	chk_shift_range: assert property (@(posedge sys_clk) disable iff (!nrst)
		ovsCtl_q[`OVS_SHIFT_MSB:`OVS_SHIFT_LSB] <= `OVS_SHIFT_MAX) // R03
		else $error("reserved shift code stored");

	chk_ratio_size: assert property (@(posedge sys_clk) disable iff (!nrst)
		(state_q == IDLE && trigEv && cfg.on) |=>
		remain_q == (9'h002 << $past(cfg.ratio))) // R04
		else $error("group size wrong");

	chk_on_bypass: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!cfg.on && groupDone) |=> result_q == {4'h0, $past(sampleData)}) // R05
		else $error("bypass result wrong");

	chk_res_upper: assert property (@(posedge sys_clk) disable iff (!nrst)
		(pready_q && !pwrite && selRes) |-> prdata_q[31:16] == 16'h0000) // R07
		else $error("result upper bits nonzero");
endmodule : adc_oversampling_control
`default_nettype wire

// >>> tb/conv_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Converter core stand-in: one sample per request, after lat plus one idle cycles
module conv_core_model
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Request and settings from the bench
	input wire logic convStart,
	input wire logic [3:0] lat,
	input wire logic [11:0] level,
	// Finished sample
	output logic sampleValid,
	output logic [11:0] sampleData
);
	logic busy_q;
	logic [3:0] cnt_q;
	// A new request restarts the delay; slow answers come from large lat
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			busy_q <= 1'b0;
			cnt_q <= 4'h0;
			sampleValid <= 1'b0;
		end
		else
		begin
			sampleValid <= busy_q && cnt_q == 4'h0;
			busy_q <= convStart || (busy_q && cnt_q != 4'h0);
			cnt_q <= convStart ? lat : cnt_q - 4'h1;
		end
	end
	// Outside a valid cycle the data bus shows garbage, never the sample
	assign sampleData = sampleValid ? level : ~level;
endmodule : conv_core_model
`default_nettype wire

// >>> tb/tb_adc_oversampling_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "ovs_defines.svh"
module tb_adc_oversampling_control;
	import ovs_pkg::*;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trigger = 1'b0;
	logic [11:0] paddr = 12'h000, level = 12'h000, sampleData;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, convStart, sampleValid, converterOn, resultValid;
	logic err;
	logic [3:0] lat = 4'h0;
	int miscompares = 0, cmp_count = 0, starts = 0;
	// Rows: control word, sample level, delay, group size, result
	localparam logic [31:0] CTL [6] = '{32'h0, 32'h1, 32'h11D, 32'h8D,
		32'h1D, 32'h225};
	localparam logic [11:0] LVL [6] = '{12'h123, 12'h123, 12'hABC,
		12'h800, 12'hFFF, 12'h100};
	localparam logic [3:0] LAT [6] = '{4'h0, 4'h3, 4'h0, 4'h1, 4'h0, 4'h2};
	localparam int NSMP [6] = '{1, 2, 256, 16, 256, 4};
	localparam logic [31:0] EXP [6] = '{32'h123, 32'h246, 32'hABC,
		32'h800, 32'hFFFF, 32'h200};

	adc_oversampling_control uut (.sys_clk(sys_clk), .nrst(nrst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .trigger(trigger), .convStart(convStart),
		.sampleValid(sampleValid), .sampleData(sampleData),
		.converterOn(converterOn), .resultValid(resultValid));
	conv_core_model core (.sys_clk(sys_clk), .nrst(nrst),
		.convStart(convStart), .lat(lat), .level(level),
		.sampleValid(sampleValid), .sampleData(sampleData));

	// Clock and request counter
	initial
	begin
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
		if (convStart === 1'b1) starts <= starts + 1;

	task automatic complete_run;
		$display("Compares %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; pready is taken as sampled at each rising edge,
	// and the request stands until that edge shows it high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		for (i = 0; i < 20 && pready !== 1'b1; i++)
			@(posedge sys_clk);
		rd = prdata;
		err = pslverr;
		if (pready !== 1'b1)
		begin
			miscompares++;
			complete_run();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	initial
	begin
		int r, i, base;
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		apb(1'b0, `OFF_OVS_CTL, 32'h0);
		check(rd, `OVS_CTL_RESET);
		for (r = 0; r < 6; r++)
		begin
			level <= LVL[r];
			lat <= LAT[r];
			apb(1'b1, `OFF_OVS_CTL, CTL[r]);
			check(err, 1'b0);
			apb(1'b0, `OFF_OVS_CTL, 32'h0);
			check(rd, CTL[r]);
			apb(1'b1, `OFF_CONV_CTL, 32'h1);
			base = starts;
			// Per-sample mode gets a trigger every 48 cycles only
			for (i = 0; i < 3000 && resultValid !== 1'b1; i++)
			begin
				@(posedge sys_clk);
				trigger <= i == 0 || (CTL[r][9] && i % 48 == 0);
				@(negedge sys_clk);
				if (CTL[r][9] && i == 47) check(starts - base, 1);
			end
			trigger <= 1'b0;
			if (resultValid !== 1'b1)
			begin
				miscompares++;
				complete_run();
			end
			check(starts - base, NSMP[r]);
			apb(1'b0, `OFF_RESULT, 32'h0);
			check(rd, EXP[r]);
			apb(1'b1, `OFF_CONV_CTL, 32'h0);
			$display("Row %0d done", r);
		end
		// Refused writes leave the settings as they were
		apb(1'b1, `OFF_CONV_CTL, 32'h1);
		check(converterOn, 1'b1);
		apb(1'b1, `OFF_OVS_CTL, 32'h1);
		check(err, 1'b1);
		apb(1'b1, `OFF_CONV_CTL, 32'h0);
		apb(1'b1, `OFF_OVS_CTL, 32'h121);
		check(err, 1'b1);
		apb(1'b0, `OFF_OVS_CTL, 32'h0);
		check(rd, CTL[5]);
		apb(1'b1, `OFF_OVS_CTL, 32'hFFFF_FC01);
		apb(1'b0, `OFF_OVS_CTL, 32'h0);
		check(rd, 32'h1);
		apb(1'b1, `OFF_RESULT, 32'h0);
		check(err, 1'b1);
		apb(1'b0, 12'h0F0, 32'h0);
		check(err, 1'b1);
		$display("Refusal test done");
		// Reset with the converter off clears the settings
		nrst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		check(converterOn, 1'b0);
		apb(1'b0, `OFF_OVS_CTL, 32'h0);
		check(rd, `OVS_CTL_RESET);
		$display("Reset test done");
		complete_run();
	end
endmodule : tb_adc_oversampling_control
`default_nettype wire
